// ---- hw/stm_defs.svh ----
// constants of the servo threshold monitor
// How it works
// [RULE1] torque over flag set when torque command at or above its threshold
// [RULE2] torque under flag set when torque command at or below its threshold
// [RULE3] speed error over flag set when error magnitude at or above threshold
// [RULE4] speed error under flag set when error magnitude at or below threshold
// [RULE5] speed over flag set when speed magnitude at or above threshold
// [RULE6] speed under flag set when speed magnitude at or below threshold
// [RULE7] signed readouts of speed, speed command and speed error
// [RULE8] index time in 0.1 ms from command acceptance to completion, saturating
// [RULE9] index time measurement restarts at every positioning completion; code clears it at completion and restarts counting at next command acceptance
// [RULE10] parameter dump lists all parameters but scale offset and multi-line setting
// [RULE11] writing a new speed loop gain clears the servo gain to zero
// [RULE12] all comparisons re-evaluated once per sample, outputs registered
`ifndef STM_DEFS_SVH
`define STM_DEFS_SVH
// register offsets
`define STM_OFS_TORQ_OVER 8'h00
`define STM_OFS_TORQ_UNDER 8'h04
`define STM_OFS_VERR_OVER 8'h08
`define STM_OFS_VERR_UNDER 8'h0c
`define STM_OFS_SPD_OVER 8'h10
`define STM_OFS_SPD_UNDER 8'h14
`define STM_OFS_SPEED 8'h18
`define STM_OFS_SPD_CMD 8'h1c
`define STM_OFS_SPD_ERR 8'h20
`define STM_OFS_INDEX_TIME 8'h24
`define STM_OFS_SPEED_GAIN 8'h28
`define STM_OFS_SERVO_GAIN 8'h2c
`define STM_OFS_ABS_OFFSET 8'h30
`define STM_OFS_MULTI_LINE 8'h34
`define STM_OFS_DUMP_CMD 8'h38
`define STM_OFS_DUMP_DATA 8'h3c
`define STM_OFS_IRQ_STATUS 8'h40
`define STM_OFS_IRQ_CLEAR 8'h44
`define STM_OFS_IRQ_ENABLE 8'h48
// parameter count and dump
`define STM_NUM_PARAMS 4'd10
`define STM_PAR_ABS_OFFSET 4'd8
`define STM_PAR_MULTI_LINE 4'd9
`define STM_DUMP_END 4'hf
// limits: torque in 0.01 %, speed in 0.001 rev/s, time in 0.1 ms
`define STM_TORQ_MAX 32'h0000_2710
`define STM_SPEED_MAX 32'h0000_2710
`define STM_TIME_MAX 32'h7fef_9fca
`define STM_TICK_NS 100000
`define STM_CLK_NS 8
`define STM_TICK_CYCLES (`STM_TICK_NS / `STM_CLK_NS)
// reset values
`define STM_RST_THRESH 32'h0000_0000
`define STM_RST_SPEED_GAIN 32'h0000_0096
`define STM_RST_PARAM 32'h0000_0000
// interrupt bit positions
`define STM_IRQ_DONE 0
`define STM_IRQ_DUMP 1
`define STM_IRQ_GAIN 2
`define STM_IRQ_BITS 3
`endif

// ---- hw/stm_pkg.sv ----
// types of the servo threshold monitor
`default_nettype none
package stm_pkg;
	typedef struct packed {
		logic signed [31:0] torque;
		logic signed [31:0] speed;
		logic signed [31:0] speedCmd;
		logic signed [31:0] speedErr;
	} stm_sample_t;
	typedef struct packed {
		logic torqueOver;
		logic torqueUnder;
		logic speedErrorOver;
		logic speedErrorUnder;
		logic speedOver;
		logic speedUnder;
	} stm_flags_t;
	typedef enum logic [2:0] {
		STM_IDLE = 3'b001,
		STM_RUN = 3'b010,
		STM_HOLD = 3'b100
	} stm_time_state_t;
endpackage
`default_nettype wire

// ---- hw/stm_monitor.sv ----
// threshold comparison, readouts, index timer and parameter dump
//
// Implementation choices: the placing of the registers and the strobed register port.
`include "stm_defs.svh"
`default_nettype none
module stm_monitor
	import stm_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic sampleValid,
	input wire stm_sample_t sample,
	input wire logic posCmdAccepted,
	input wire logic posComplete,
	input wire logic [7:0] addr,
	input wire logic [31:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [31:0] rdData,
	output stm_flags_t flags,
	output logic irq
);
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] magOf(input logic signed [31:0] v);
		magOf = v[31] ? 32'(-v) : v;
	endfunction
	function automatic logic [31:0] clampOf(input logic [31:0] v, input logic [31:0] lim);
		clampOf = (v > lim) ? lim : v;
	endfunction

	////////////////////////////////////////////////////////////////
	// parameter store
	logic [31:0] param_reg [`STM_NUM_PARAMS];
	logic [31:0] param_next [`STM_NUM_PARAMS];
	logic [3:0] dumpIdx_reg, dumpIdx_next;
	logic gainEvt;

	function automatic logic [3:0] parIdx(input logic [7:0] a);
		parIdx = 4'(a[7:2]);
	endfunction
	function automatic logic isPar(input logic [7:0] a);
		// thresholds below the readouts, gains and settings between readouts and dump
		isPar = (a[1:0] == 2'b00) && ((a < `STM_OFS_SPEED)
			|| (a >= `STM_OFS_SPEED_GAIN && a < `STM_OFS_DUMP_CMD));
	endfunction
	// storage index: thresholds 0..5, gain 6, servo gain 7, offset 8, multi-line 9
	function automatic logic [3:0] storeIdx(input logic [7:0] a);
		unique case (a)
			`STM_OFS_SPEED_GAIN: storeIdx = 4'd6;
			`STM_OFS_SERVO_GAIN: storeIdx = 4'd7;
			`STM_OFS_ABS_OFFSET: storeIdx = `STM_PAR_ABS_OFFSET;
			`STM_OFS_MULTI_LINE: storeIdx = `STM_PAR_MULTI_LINE;
			default: storeIdx = parIdx(a);
		endcase
	endfunction
	function automatic logic [31:0] limOf(input logic [3:0] i);
		limOf = (i < 4'd2) ? `STM_TORQ_MAX : (i < 4'd6) ? `STM_SPEED_MAX : 32'hffff_ffff;
	endfunction

	always_comb begin
		logic [3:0] w;
		w = storeIdx(addr);
		gainEvt = 1'b0;
		for (int i = 0; i < `STM_NUM_PARAMS; i++) begin
			param_next[i] = param_reg[i];
		end
		if (wrStrobe && isPar(addr)) begin
			param_next[w] = clampOf(wrData, limOf(w));
			if (w == 4'd6 && wrData != param_reg[6]) begin
				param_next[7] = '0; // RULE11
				gainEvt = 1'b1;
			end
		end
		dumpIdx_next = dumpIdx_reg;
		if (wrStrobe && addr == `STM_OFS_DUMP_CMD) begin
			dumpIdx_next = 4'd0;
		end else if (rdStrobe && addr == `STM_OFS_DUMP_DATA && dumpIdx_reg != `STM_DUMP_END) begin
			// offset and multi-line are the last two slots, so the dump ends before them
			dumpIdx_next = (dumpIdx_reg + 4'd1 >= `STM_PAR_ABS_OFFSET) ? `STM_DUMP_END
				: dumpIdx_reg + 4'd1; // RULE10
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `STM_NUM_PARAMS; i++) begin
				param_reg[i] <= (i == 6) ? `STM_RST_SPEED_GAIN : `STM_RST_PARAM;
			end
			dumpIdx_reg <= `STM_DUMP_END;
		end else begin
			param_reg <= param_next;
			dumpIdx_reg <= dumpIdx_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// comparisons and readouts, refreshed per sample
	stm_flags_t flags_reg, flags_next;
	stm_sample_t smp_reg, smp_next;

	always_comb begin
		flags_next = flags_reg;
		smp_next = smp_reg;
		if (sampleValid) begin // RULE12
			smp_next = sample; // RULE7
			flags_next.torqueOver = $signed(sample.torque) >= $signed(param_reg[0]); // RULE1
			flags_next.torqueUnder = $signed(sample.torque) <= $signed(param_reg[1]); // RULE2
			flags_next.speedErrorOver = magOf(sample.speedErr) >= param_reg[2]; // RULE3
			flags_next.speedErrorUnder = magOf(sample.speedErr) <= param_reg[3]; // RULE4
			flags_next.speedOver = magOf(sample.speed) >= param_reg[4]; // RULE5
			flags_next.speedUnder = magOf(sample.speed) <= param_reg[5]; // RULE6
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			flags_reg <= '0;
			smp_reg <= '0;
		end else begin
			flags_reg <= flags_next;
			smp_reg <= smp_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// index timer in 0.1 ms units
	stm_time_state_t tState_reg, tState_next;
	logic [31:0] tCount_reg, tCount_next;
	logic [31:0] tTime_reg, tTime_next;
	logic [15:0] tPre_reg, tPre_next;
	logic doneEvt;

	always_comb begin
		tState_next = tState_reg;
		tCount_next = tCount_reg;
		tTime_next = tTime_reg;
		tPre_next = tPre_reg;
		doneEvt = 1'b0;
		unique case (tState_reg)
			STM_IDLE, STM_HOLD: begin
				if (posCmdAccepted) begin
					tState_next = STM_RUN;
					tCount_next = '0;
					tPre_next = '0;
				end
			end
			STM_RUN: begin
				if (tPre_reg == 16'(`STM_TICK_CYCLES - 1)) begin
					tPre_next = '0;
					if (tCount_reg < `STM_TIME_MAX) begin
						tCount_next = tCount_reg + 32'd1; // RULE8
					end
				end else begin
					tPre_next = tPre_reg + 16'd1;
				end
				if (posComplete) begin
					tTime_next = tCount_reg;
					tCount_next = '0; // RULE9
					tState_next = STM_HOLD;
					doneEvt = 1'b1;
				end
			end
			default: tState_next = STM_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tState_reg <= STM_IDLE;
			tCount_reg <= '0;
			tTime_reg <= '0;
			tPre_reg <= '0;
		end else begin
			tState_reg <= tState_next;
			tCount_reg <= tCount_next;
			tTime_reg <= tTime_next;
			tPre_reg <= tPre_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupts and read port
	logic [`STM_IRQ_BITS-1:0] irqStat_reg, irqStat_next;
	logic [`STM_IRQ_BITS-1:0] irqEn_reg, irqEn_next;
	logic irq_reg, irq_next;
	logic [31:0] rd_reg, rd_next;
	logic dumpEvt;

	always_comb begin
		logic [`STM_IRQ_BITS-1:0] evt;
		evt = '0;
		dumpEvt = rdStrobe && addr == `STM_OFS_DUMP_DATA && dumpIdx_next == `STM_DUMP_END
			&& dumpIdx_reg != `STM_DUMP_END;
		evt[`STM_IRQ_DONE] = doneEvt;
		evt[`STM_IRQ_DUMP] = dumpEvt;
		evt[`STM_IRQ_GAIN] = gainEvt;
		irqStat_next = irqStat_reg;
		if (wrStrobe && addr == `STM_OFS_IRQ_CLEAR) begin
			irqStat_next = irqStat_reg & ~wrData[`STM_IRQ_BITS-1:0];
		end
		irqStat_next = irqStat_next | evt;
		irqEn_next = irqEn_reg;
		if (wrStrobe && addr == `STM_OFS_IRQ_ENABLE) begin
			irqEn_next = wrData[`STM_IRQ_BITS-1:0];
		end
		irq_next = |(irqStat_next & irqEn_next);
		rd_next = '0;
		if (rdStrobe) begin
			if (isPar(addr)) begin
				rd_next = param_reg[storeIdx(addr)];
			end else begin
				unique case (addr)
					`STM_OFS_SPEED: rd_next = smp_reg.speed; // RULE7
					`STM_OFS_SPD_CMD: rd_next = smp_reg.speedCmd;
					`STM_OFS_SPD_ERR: rd_next = smp_reg.speedErr;
					`STM_OFS_INDEX_TIME: rd_next = tTime_reg;
					`STM_OFS_DUMP_DATA: rd_next = (dumpIdx_reg == `STM_DUMP_END) ? '0
						: param_reg[dumpIdx_reg];
					`STM_OFS_IRQ_STATUS: rd_next = 32'(irqStat_reg);
					`STM_OFS_IRQ_ENABLE: rd_next = 32'(irqEn_reg);
					default: rd_next = '0;
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irqStat_reg <= '0;
			irqEn_reg <= '0;
			irq_reg <= 1'b0;
			rd_reg <= '0;
		end else begin
			irqStat_reg <= irqStat_next;
			irqEn_reg <= irqEn_next;
			irq_reg <= irq_next;
			rd_reg <= rd_next;
		end
	end

	assign rdData = rd_reg;
	assign flags = flags_reg;
	assign irq = irq_reg;

	////////////////////////////////////////////////////////////////
	sequence gainWrite;
		wrStrobe && addr == `STM_OFS_SPEED_GAIN && wrData != param_reg[6];
	endsequence
	chk_gain_clears_servo: assert property (@(posedge clock) disable iff (!rstn) // RULE11
		gainWrite |=> param_reg[7] == 32'h0)
		else $error("servo gain not cleared");
	chk_torque_over: assert property (@(posedge clock) disable iff (!rstn) // RULE1
		sampleValid |=> flags.torqueOver ==
			($signed($past(sample.torque)) >= $signed($past(param_reg[0]))))
		else $error("torque over flag wrong");
	chk_torque_under: assert property (@(posedge clock) disable iff (!rstn) // RULE2
		sampleValid |=> flags.torqueUnder ==
			($signed($past(sample.torque)) <= $signed($past(param_reg[1]))))
		else $error("torque under flag wrong");
	chk_err_over: assert property (@(posedge clock) disable iff (!rstn) // RULE3
		sampleValid |=> flags.speedErrorOver ==
			(magOf($past(sample.speedErr)) >= $past(param_reg[2])))
		else $error("speed error over flag wrong");
	chk_err_under: assert property (@(posedge clock) disable iff (!rstn) // RULE4
		sampleValid |=> flags.speedErrorUnder ==
			(magOf($past(sample.speedErr)) <= $past(param_reg[3])))
		else $error("speed error under flag wrong");
	chk_speed_over: assert property (@(posedge clock) disable iff (!rstn) // RULE5
		sampleValid |=> flags.speedOver ==
			(magOf($past(sample.speed)) >= $past(param_reg[4])))
		else $error("speed over flag wrong");
	chk_speed_under: assert property (@(posedge clock) disable iff (!rstn) // RULE6
		sampleValid |=> flags.speedUnder ==
			(magOf($past(sample.speed)) <= $past(param_reg[5])))
		else $error("speed under flag wrong");
	chk_flags_hold: assert property (@(posedge clock) disable iff (!rstn) // RULE12
		!sampleValid |=> $stable(flags))
		else $error("flags moved without sample");
	chk_time_restart: assert property (@(posedge clock) disable iff (!rstn) // RULE9
		tState_reg == STM_RUN && posComplete |=> tCount_reg == 32'h0 && tTime_reg == $past(tCount_reg))
		else $error("index time not restarted");
	chk_time_sat: assert property (@(posedge clock) disable iff (!rstn) // RULE8
		tCount_reg <= `STM_TIME_MAX)
		else $error("index time beyond maximum");
	chk_dump_skip: assert property (@(posedge clock) disable iff (!rstn) // RULE10
		dumpIdx_reg != `STM_PAR_ABS_OFFSET && dumpIdx_reg != `STM_PAR_MULTI_LINE)
		else $error("dump reached excluded parameter");
	sequence dumpLastRead;
		rdStrobe && addr == `STM_OFS_DUMP_DATA && dumpIdx_reg == 4'd7;
	endsequence
	sequence gainRewrite;
		wrStrobe && addr == `STM_OFS_SPEED_GAIN && wrData == param_reg[6];
	endsequence
	chk_dump_end: assert property (@(posedge clock) disable iff (!rstn) // RULE10
		dumpLastRead |=> dumpIdx_reg == `STM_DUMP_END && irqStat_reg[`STM_IRQ_DUMP])
		else $error("dump did not end after last parameter");
	chk_gain_kept: assert property (@(posedge clock) disable iff (!rstn) // RULE11
		gainRewrite |=> $stable(param_reg[7]))
		else $error("servo gain cleared without gain change");
	chk_time_start: assert property (@(posedge clock) disable iff (!rstn) // RULE8
		tState_reg != STM_RUN && posCmdAccepted |=> tState_reg == STM_RUN && tCount_reg == 32'h0)
		else $error("index time did not start");
	chk_done_status: assert property (@(posedge clock) disable iff (!rstn) // RULE9
		tState_reg == STM_RUN && posComplete |=> irqStat_reg[`STM_IRQ_DONE])
		else $error("completion status not set");
	chk_speed_readout: assert property (@(posedge clock) disable iff (!rstn) // RULE7
		rdStrobe && addr == `STM_OFS_SPEED |=> rdData == $past(smp_reg.speed))
		else $error("speed readout wrong");
	chk_read_idle: assert property (@(posedge clock) disable iff (!rstn) // RULE7
		!rdStrobe |=> rdData == 32'h0)
		else $error("read data not zero without read");
endmodule
`default_nettype wire

// ---- tb/stm_servo_model.sv ----
// servo loop stand-in feeding samples and positioning events
`default_nettype none
module stm_servo_model
	import stm_pkg::*;
(
	input wire logic clock,
	output logic sampleValid,
	output stm_sample_t sample,
	output logic posCmdAccepted,
	output logic posComplete
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sampleValid = 1'b0;
		sample = '0;
		posCmdAccepted = 1'b0;
		posComplete = 1'b0;
	end
	// sample lines scrambled once the valid pulse is over
	task automatic send(input stm_sample_t s);
		sampleValid <= 1'b1;
		sample <= s;
		@(posedge clock);
		sampleValid <= 1'b0;
		sample <= ~s;
	endtask
	task automatic pulse(input logic done);
		posCmdAccepted <= !done;
		posComplete <= done;
		@(posedge clock);
		posCmdAccepted <= 1'b0;
		posComplete <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/servo_threshold_monitor_outputs_tb.sv ----
// self-checking bench of the servo threshold monitor
`include "stm_defs.svh"
`default_nettype none
module servo_threshold_monitor_outputs_tb;
	import stm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = '0;
	logic [31:0] wrData = '0;
	logic wrStrobe = 1'b0;
	logic rdStrobe = 1'b0;
	logic [31:0] rdData;
	stm_flags_t flags;
	logic irq;
	logic sampleValid;
	logic posCmdAccepted;
	logic posComplete;
	stm_sample_t sample;
	int errTotal = 0;
	int totalChecks = 0;
	int thr [6];
	int dumpQ [$];
	logic [31:0] v;
	always #4 clock = ~clock;
	stm_monitor stm_monitor_i (.clock(clock), .rstn(rstn), .sampleValid(sampleValid),
		.sample(sample), .posCmdAccepted(posCmdAccepted), .posComplete(posComplete),
		.addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.rdData(rdData), .flags(flags), .irq(irq));
	stm_servo_model stm_servo_model_i (.clock(clock), .sampleValid(sampleValid),
		.sample(sample), .posCmdAccepted(posCmdAccepted), .posComplete(posComplete));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clock);
		wrStrobe <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clock);
		rdStrobe <= 1'b0;
		#1;
		d = rdData;
		@(posedge clock);
	endtask
	task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a, v);
		chk(n, v, e);
	endtask
	task automatic tallyAndFinish;
		$display("checks %0d errors %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	function automatic int mag(input int x);
		return x < 0 ? -x : x;
	endfunction
	function automatic int rnd();
		return int'($urandom_range(0, 20000)) - 10000;
	endfunction
	task automatic sampleChk(input int t, input int s, input int c, input int e);
		logic [5:0] exp;
		stm_servo_model_i.send({t, s, c, e});
		#1;
		exp = {t >= thr[0], t <= thr[1], mag(e) >= thr[2], mag(e) <= thr[3],
			mag(s) >= thr[4], mag(s) <= thr[5]};
		chk("flags", 32'(flags), 32'(exp));
		@(posedge clock);
		rdChk("speed", `STM_OFS_SPEED, 32'(s));
		rdChk("speed command", `STM_OFS_SPD_CMD, 32'(c));
		rdChk("speed error", `STM_OFS_SPD_ERR, 32'(e));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(73));
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 6; i++)
			rdChk("threshold reset", 8'(4 * i), 32'h0000_0000);
		rdChk("gain reset", `STM_OFS_SPEED_GAIN, 32'h0000_0096);
		wr(8'h4c, 32'h0000_1234);
		rdChk("unmapped", 8'h4c, 32'h0000_0000);
		wr(`STM_OFS_TORQ_OVER, 32'h0000_ffff);
		thr[0] = 10000;
		rdChk("clamp", `STM_OFS_TORQ_OVER, 32'h0000_2710);
		for (int i = 1; i < 6; i++) begin
			thr[i] = $urandom_range(0, 10000);
			wr(8'(4 * i), 32'(thr[i]));
		end
		// exact boundary value of every comparison, speed and error with both signs
		sampleChk(thr[0], -thr[4], 7, thr[2]);
		sampleChk(thr[1], thr[5], 0, -thr[3]);
		for (int j = 0; j < 30; j++) begin
			thr[j % 6] = $urandom_range(0, 10000);
			wr(8'(4 * (j % 6)), 32'(thr[j % 6]));
			sampleChk(rnd(), rnd(), rnd(), rnd());
		end
		wr(`STM_OFS_IRQ_ENABLE, 32'h0000_0007);
		wr(`STM_OFS_SERVO_GAIN, 32'h0000_0005);
		wr(`STM_OFS_SPEED_GAIN, 32'h0000_0096);
		rdChk("servo gain kept", `STM_OFS_SERVO_GAIN, 32'h0000_0005);
		wr(`STM_OFS_SPEED_GAIN, 32'h0000_0100);
		rdChk("servo gain", `STM_OFS_SERVO_GAIN, 32'h0000_0000);
		rdChk("gain status", `STM_OFS_IRQ_STATUS, 32'h0000_0004);
		chk("gain irq", 32'(irq), 32'h0000_0001);
		wr(`STM_OFS_IRQ_CLEAR, 32'h0000_0004);
		rdChk("cleared status", `STM_OFS_IRQ_STATUS, 32'h0000_0000);
		chk("cleared irq", 32'(irq), 32'h0000_0000);
		wr(`STM_OFS_SERVO_GAIN, 32'h0000_0007);
		wr(`STM_OFS_ABS_OFFSET, 32'h0000_0055);
		wr(`STM_OFS_MULTI_LINE, 32'h0000_0066);
		rdChk("scale offset", `STM_OFS_ABS_OFFSET, 32'h0000_0055);
		rdChk("multi-line", `STM_OFS_MULTI_LINE, 32'h0000_0066);
		wr(`STM_OFS_DUMP_CMD, 32'h0000_0001);
		dumpQ = {thr[0], thr[1], thr[2], thr[3], thr[4], thr[5], 256, 7, 0};
		foreach (dumpQ[i])
			rdChk("dump", `STM_OFS_DUMP_DATA, 32'(dumpQ[i]));
		rd(`STM_OFS_IRQ_STATUS, v);
		chk("dump status", v & 32'h0000_0002, 32'h0000_0002);
		wr(`STM_OFS_IRQ_ENABLE, 32'h0000_0000);
		wr(`STM_OFS_IRQ_CLEAR, 32'h0000_0007);
		stm_servo_model_i.pulse(1'b0);
		repeat (2 * `STM_TICK_CYCLES + 100) @(posedge clock);
		stm_servo_model_i.pulse(1'b1);
		rdChk("index time", `STM_OFS_INDEX_TIME, 32'h0000_0002);
		chk("masked irq", 32'(irq), 32'h0000_0000);
		wr(`STM_OFS_IRQ_ENABLE, 32'h0000_0001);
		rdChk("done status", `STM_OFS_IRQ_STATUS, 32'h0000_0001);
		chk("done irq", 32'(irq), 32'h0000_0001);
		stm_servo_model_i.pulse(1'b0);
		repeat (`STM_TICK_CYCLES + 100) @(posedge clock);
		stm_servo_model_i.pulse(1'b1);
		rdChk("restarted time", `STM_OFS_INDEX_TIME, 32'h0000_0001);
		tallyAndFinish();
	end
	initial begin
		#600000;
		errTotal++;
		tallyAndFinish();
	end
endmodule
`default_nettype wire
